// [common/nibble_cpu_pkg.sv]
// Package: encodings, field layouts and state types of the transfer core
package nibble_cpu_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int INSTR_W = 10;
    localparam int NIB_W = 4;
    localparam int PAGE_W = 6;
    localparam int LOW_W = 7;
    localparam int PC_W = PAGE_W + LOW_W;
    localparam int SP_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam int Z_W = 2;
    localparam int D_W = 3;
    localparam int RAM_ADDR_W = Z_W + NIB_W + NIB_W;

    // ------------------------------------------------------------
    // Opcode bases and compare masks
    // ------------------------------------------------------------
    localparam logic [9:0] OP_STACK_TO_ACC = 10'h050;
    localparam logic [9:0] OP_PAIR_LOAD = 10'h300;
    localparam logic [9:0] MASK_PAIR_LOAD = 10'h300;
    localparam logic [9:0] OP_BANK_LOAD = 10'h048;
    localparam logic [9:0] MASK_BANK_LOAD = 10'h3FC;
    localparam logic [9:0] OP_Y_INC = 10'h013;
    localparam logic [9:0] OP_Y_DEC = 10'h017;
    localparam logic [9:0] OP_MEM_TO_ACC = 10'h2C0;
    localparam logic [9:0] OP_MEM_XCHG = 10'h2D0;
    localparam logic [9:0] OP_XCHG_INC = 10'h2E0;
    localparam logic [9:0] OP_XCHG_DEC = 10'h2F0;
    localparam logic [9:0] OP_ACC_TO_MEM = 10'h2B0;
    localparam logic [9:0] MASK_J_FIELD = 10'h3F0;
    localparam logic [9:0] OP_ACC_IMM = 10'h070;
    localparam logic [9:0] OP_TABLE_REF = 10'h080;
    localparam logic [9:0] MASK_TABLE_REF = 10'h3C0;
    localparam logic [9:0] OP_ADD_MEM = 10'h00A;

    // ------------------------------------------------------------
    // Skip conditions and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] Y_INC_SKIP_VAL = 4'h0;
    localparam logic [3:0] Y_DEC_SKIP_VAL = 4'hF;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [SP_W-1:0] SP_RESET = 3'h7;
    localparam logic [3:0] NIB_RESET = 4'h0;

    // Decoded operation
    typedef enum {
        OPC_NOP, OPC_STACK_TO_ACC, OPC_PAIR_LOAD, OPC_BANK_LOAD,
        OPC_Y_INC, OPC_Y_DEC, OPC_MEM_TO_ACC, OPC_MEM_XCHG,
        OPC_XCHG_DEC, OPC_XCHG_INC, OPC_ACC_TO_MEM, OPC_ACC_IMM,
        OPC_TABLE_REF, OPC_ADD_MEM
    } op_type;

    // Sequencer state
    typedef enum {ST_EXEC, ST_TABLE_READ, ST_TABLE_RETURN} seq_state_type;

    // Visible register set
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [SP_W-1:0] stack_pointer;
        logic [3:0] acc;
        logic [3:0] b;
        logic [3:0] x;
        logic [3:0] y;
        logic [Z_W-1:0] z;
        logic [D_W-1:0] three_bit_data_reg;
    } core_regs_type;

    // RAM write request
    typedef struct packed {
        logic we;
        logic [RAM_ADDR_W-1:0] addr;
        logic [3:0] wdata;
    } ram_req_type;

endpackage

// [verilog/nibble_cpu_transfer_exec.sv]
// Transfer-group execution core: fetch, decode, skip and table reference
`timescale 1ns/1ns
// Function
// - Stack-to-acc transfer copies stack pointer into acc bits 2..0.
// - Pointer pair load writes x field to X, y field to Y.
// - In a run of pointer pair loads only the first executes.
// - Bank load writes z field into Z.
// - Y increment adds one, skips next when result is zero.
// - Y decrement subtracts one, skips next when result is fifteen.
// - Mem-to-acc load copies M(DP) to acc, then X ^= j.
// - Memory exchange swaps M(DP) and acc, then X ^= j.
// - Exchange-and-decrement: exchange, X ^= j, Y-1, skip on fifteen.
// - Exchange-and-increment: exchange, X ^= j, Y+1, skip on zero.
// - Acc-to-mem store writes acc to M(DP), then X ^= j.
// - Immediate acc load (07n) loads n, one word, one cycle.
// - Table reference: push PC, jump to {p, D, A}, three cycles.
// - Table word bits 7..4 to B, 3..0 to acc; then pop PC.
// - Add memory (00A) sets acc to acc plus M(DP), one cycle.
// - The j field is four bits, values zero to fifteen.
module nibble_cpu_transfer_exec
    import nibble_cpu_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [INSTR_W-1:0] rom_data_in,
    input wire logic [3:0] ram_rdata_in,
    output logic [PC_W-1:0] rom_addr_out,
    output ram_req_type ram_req_out,
    output core_regs_type regs_out,
    output logic skip_pending_out
);

    // ------------------------------------------------------------
    // Timing notes
    // ------------------------------------------------------------
    // Fetch: the word at rom_addr_out is decoded in the same cycle,
    // so the ROM must answer combinationally; a registered ROM would
    // need an extra pipeline stage and a different skip timing.
    //
    // RAM: the address is built from Z, X and Y as they stand before
    // the edge. An exchange reads the old nibble and writes the old
    // accumulator at the same edge, so the RAM must read before it
    // writes within one cycle.
    //
    // Skip: the skip flag is set by the counting instructions and is
    // consumed by the very next executed word. That word still moves
    // the program counter on by one but touches nothing else.
    //
    // Pair load runs: the run flag follows every fetched word in the
    // execute state, skipped ones included, so a run broken only by
    // a skip still counts as one run. A table reference ends a run
    // because its return cycle clears the flag.
    //
    // Table reference: three cycles in all.
    //   cycle 0  push pc+1, bump the stack pointer, jump into the table
    //   cycle 1  the fetched table word fills B and the accumulator
    //   cycle 2  pop the return address, drop the stack pointer
    // Bits 9 and 8 of the table word are ignored.
    //
    // Limitation: the return stack does not guard against overflow;
    // nesting deeper than its entries silently wraps the pointer.
    //
    // Trade-off: the write strobe is left combinational so that an
    // exchange needs no second cycle; addresses and data stay on
    // flip-flops to keep the RAM inputs glitch free.

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Opcode decode from fixed bits; unlisted codes fall to no-op
    function automatic op_type decode_op(input logic [9:0] w);
        op_type op;
        op = OPC_NOP;
        if (w == OP_STACK_TO_ACC) begin
            op = OPC_STACK_TO_ACC;
        end else if ((w & MASK_PAIR_LOAD) == OP_PAIR_LOAD) begin
            op = OPC_PAIR_LOAD;
        end else if ((w & MASK_BANK_LOAD) == OP_BANK_LOAD) begin
            op = OPC_BANK_LOAD;
        end else if (w == OP_Y_INC) begin
            op = OPC_Y_INC;
        end else if (w == OP_Y_DEC) begin
            op = OPC_Y_DEC;
        end else if ((w & MASK_J_FIELD) == OP_MEM_TO_ACC) begin
            op = OPC_MEM_TO_ACC;
        end else if ((w & MASK_J_FIELD) == OP_MEM_XCHG) begin
            op = OPC_MEM_XCHG;
        end else if ((w & MASK_J_FIELD) == OP_XCHG_DEC) begin
            op = OPC_XCHG_DEC;
        end else if ((w & MASK_J_FIELD) == OP_XCHG_INC) begin
            op = OPC_XCHG_INC;
        end else if ((w & MASK_J_FIELD) == OP_ACC_TO_MEM) begin
            op = OPC_ACC_TO_MEM;
        end else if ((w & MASK_J_FIELD) == OP_ACC_IMM) begin
            op = OPC_ACC_IMM;
        end else if ((w & MASK_TABLE_REF) == OP_TABLE_REF) begin
            op = OPC_TABLE_REF;
        end else if (w == OP_ADD_MEM) begin
            op = OPC_ADD_MEM;
        end
        return op;
    endfunction

    // Four-bit step used by Y counting instructions
    function automatic logic [3:0] nib_step(input logic [3:0] v,
                                            input logic up);
        return up ? 4'(v + 4'h1) : 4'(v - 4'h1);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    seq_state_type state_q, state_d;
    core_regs_type regs_q, regs_d;
    logic skip_q, skip_d;
    logic pair_run_q, pair_run_d;
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic stack_we;
    logic [SP_W-1:0] stack_idx;
    logic [PC_W-1:0] stack_wdata;
    ram_req_type ram_req;
    op_type op;
    logic [3:0] imm_nib;
    logic [1:0] imm_x;
    logic [PC_W-1:0] pc_next;
    logic [SP_W-1:0] sp_inc;
    logic squash;

    // Immediate fields sit in the low bits of the word
    assign op = decode_op(rom_data_in);
    assign imm_nib = rom_data_in[3:0];
    assign imm_x = rom_data_in[5:4];
    assign pc_next = PC_W'(regs_q.pc + 13'h0001);
    assign sp_inc = SP_W'(regs_q.stack_pointer + 3'h1);

    // A pending skip or a repeated pair load turns the word into a no-op
    assign squash = skip_q ||
        (op == OPC_PAIR_LOAD && pair_run_q);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // One word per cycle; table reference borrows two more cycles
    always_comb begin
        state_d = state_q;
        regs_d = regs_q;
        skip_d = skip_q;
        pair_run_d = pair_run_q;
        stack_we = 1'b0;
        stack_idx = regs_q.stack_pointer;
        stack_wdata = pc_next;
        ram_req.we = 1'b0;
        ram_req.addr = {regs_q.z, regs_q.x, regs_q.y};
        ram_req.wdata = regs_q.acc;
        unique case (state_q)
            ST_EXEC: begin
                regs_d.pc = pc_next;
                skip_d = 1'b0;
                // Run tracking sees skipped pair loads too
                pair_run_d = (op == OPC_PAIR_LOAD);
                if (!squash) begin
                    unique case (op)
                        OPC_STACK_TO_ACC: begin
                            regs_d.acc = {1'b0,
                                regs_q.stack_pointer};
                        end
                        OPC_PAIR_LOAD: begin
                            regs_d.x = {2'b00, imm_x};
                            regs_d.y = imm_nib;
                        end
                        OPC_BANK_LOAD: begin
                            regs_d.z = imm_nib[1:0];
                        end
                        OPC_Y_INC: begin
                            regs_d.y = nib_step(regs_q.y, 1'b1);
                            skip_d = (regs_d.y ==
                                Y_INC_SKIP_VAL);
                        end
                        OPC_Y_DEC: begin
                            regs_d.y = nib_step(regs_q.y, 1'b0);
                            skip_d = (regs_d.y ==
                                Y_DEC_SKIP_VAL);
                        end
                        OPC_MEM_TO_ACC: begin
                            regs_d.acc = ram_rdata_in;
                            regs_d.x = regs_q.x ^ imm_nib;
                        end
                        OPC_MEM_XCHG: begin
                            ram_req.we = 1'b1;
                            regs_d.acc = ram_rdata_in;
                            regs_d.x = regs_q.x ^ imm_nib;
                        end
                        OPC_XCHG_DEC: begin
                            ram_req.we = 1'b1;
                            regs_d.acc = ram_rdata_in;
                            regs_d.x = regs_q.x ^ imm_nib;
                            regs_d.y = nib_step(regs_q.y, 1'b0);
                            skip_d = (regs_d.y ==
                                Y_DEC_SKIP_VAL);
                        end
                        OPC_XCHG_INC: begin
                            ram_req.we = 1'b1;
                            regs_d.acc = ram_rdata_in;
                            regs_d.x = regs_q.x ^ imm_nib;
                            regs_d.y = nib_step(regs_q.y, 1'b1);
                            skip_d = (regs_d.y ==
                                Y_INC_SKIP_VAL);
                        end
                        OPC_ACC_TO_MEM: begin
                            ram_req.we = 1'b1;
                            regs_d.x = regs_q.x ^ imm_nib;
                        end
                        OPC_ACC_IMM: begin
                            regs_d.acc = imm_nib;
                        end
                        OPC_TABLE_REF: begin
                            // Push return address, jump into the table
                            regs_d.stack_pointer = sp_inc;
                            stack_we = 1'b1;
                            stack_idx = sp_inc;
                            regs_d.pc = {rom_data_in[5:0],
                                regs_q.three_bit_data_reg,
                                regs_q.acc};
                            state_d = ST_TABLE_READ;
                        end
                        OPC_ADD_MEM: begin
                            regs_d.acc = 4'(regs_q.acc +
                                ram_rdata_in);
                        end
                        OPC_NOP: begin
                            regs_d.acc = regs_q.acc;
                        end
                    endcase
                end
            end
            ST_TABLE_READ: begin
                // ROM now shows the table word at the jump address
                regs_d.b = rom_data_in[7:4];
                regs_d.acc = rom_data_in[3:0];
                state_d = ST_TABLE_RETURN;
            end
            ST_TABLE_RETURN: begin
                // Pop back to the word after the table reference
                regs_d.pc = stack_q[regs_q.stack_pointer];
                regs_d.stack_pointer = SP_W'(regs_q.stack_pointer -
                    3'h1);
                pair_run_d = 1'b0;
                state_d = ST_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Core state; RAM has no reset, but every core register starts known
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_EXEC;
            regs_q.pc <= PC_RESET;
            regs_q.stack_pointer <= SP_RESET;
            regs_q.acc <= NIB_RESET;
            regs_q.b <= NIB_RESET;
            regs_q.x <= NIB_RESET;
            regs_q.y <= NIB_RESET;
            regs_q.z <= 2'b00;
            regs_q.three_bit_data_reg <= 3'b000;
            skip_q <= 1'b0;
            pair_run_q <= 1'b0;
        end else begin
            state_q <= state_d;
            regs_q <= regs_d;
            skip_q <= skip_d;
            pair_run_q <= pair_run_d;
        end
    end

    // Return stack; one write port, written only by table reference
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= PC_RESET;
            end
        end else if (stack_we) begin
            stack_q[stack_idx] <= stack_wdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Write strobe is combinational so exchange reads and writes in one go
    assign ram_req_out = ram_req;
    assign rom_addr_out = regs_q.pc;
    assign regs_out = regs_q;
    assign skip_pending_out = skip_q;

endmodule // nibble_cpu_transfer_exec

// [dv/nibble_cpu_exec_properties.sv]
// Checker: port-level properties of the transfer execution core
`timescale 1ns/1ns
module nibble_cpu_exec_properties
    import nibble_cpu_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [INSTR_W-1:0] rom_data_in,
    input wire logic [3:0] ram_rdata_in,
    input wire logic [PC_W-1:0] rom_addr_out,
    input ram_req_type ram_req_out,
    input core_regs_type regs_out,
    input wire logic skip_pending_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    logic [1:0] tbl_q;
    logic [1:0] tbl_d;
    logic live;
    // Word slots of a table reference carry data, not opcodes
    assign live = (tbl_q == 2'h0) && !skip_pending_out;
    always_comb begin
        tbl_d = (tbl_q != 2'h0) ? tbl_q - 2'h1 : 2'h0;
        if (live && rom_data_in[9:6] == 4'h2) begin
            tbl_d = 2'h2;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tbl_q <= 2'h0;
        end else begin
            tbl_q <= tbl_d;
        end
    end
    // Table reference steps: jump, table word, return
    sequence s_tbl_jump;
        regs_out.pc == {$past(rom_data_in[5:0]),
            $past(regs_out.three_bit_data_reg), $past(regs_out.acc)}
        && regs_out.stack_pointer - $past(regs_out.stack_pointer) == 3'h1;
    endsequence
    sequence s_tbl_word;
        regs_out.b == $past(rom_data_in[7:4])
        && regs_out.acc == $past(rom_data_in[3:0]);
    endsequence
    sequence s_tbl_back;
        regs_out.pc - $past(regs_out.pc, 3) == 13'h0001
        && regs_out.stack_pointer == $past(regs_out.stack_pointer, 3);
    endsequence
    property p_table;
        live && rom_data_in[9:6] == 4'h2 |=>
            s_tbl_jump ##1 s_tbl_word ##1 s_tbl_back;
    endproperty
    a_table: assert property (p_table)
        else $error("table reference sequence wrong");
    property p_fetch;
        rom_addr_out == regs_out.pc;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch address differs from pc");
    property p_acc_imm;
        live && rom_data_in[9:4] == 6'h07 |=>
            regs_out.acc == $past(rom_data_in[3:0]);
    endproperty
    a_acc_imm: assert property (p_acc_imm)
        else $error("immediate load wrong");
    property p_bank;
        live && rom_data_in[9:2] == 8'h12 |=>
            regs_out.z == $past(rom_data_in[1:0]);
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank load wrong");
    property p_y_inc;
        live && rom_data_in == OP_Y_INC |=>
            regs_out.y - $past(regs_out.y) == 4'h1
            && skip_pending_out == (regs_out.y == Y_INC_SKIP_VAL);
    endproperty
    a_y_inc: assert property (p_y_inc)
        else $error("y increment or its skip wrong");
    property p_y_dec;
        live && rom_data_in == OP_Y_DEC |=>
            $past(regs_out.y) - regs_out.y == 4'h1
            && skip_pending_out == (regs_out.y == Y_DEC_SKIP_VAL);
    endproperty
    a_y_dec: assert property (p_y_dec)
        else $error("y decrement or its skip wrong");
    property p_xor;
        live && rom_data_in[9:4] inside {[6'h2B:6'h2F]} |=>
            regs_out.x == ($past(regs_out.x) ^ $past(rom_data_in[3:0]));
    endproperty
    a_xor: assert property (p_xor)
        else $error("x update wrong");
    property p_store;
        live && rom_data_in[9:4] == 6'h2B |-> ram_req_out.we
            && ram_req_out.wdata == regs_out.acc
            && ram_req_out.addr == {regs_out.z, regs_out.x, regs_out.y};
    endproperty
    a_store: assert property (p_store)
        else $error("store write wrong");
    property p_skip_quiet;
        skip_pending_out && tbl_q == 2'h0 |-> !ram_req_out.we ##1
            $stable(regs_out.acc) && $stable(regs_out.x)
            && $stable(regs_out.y) && $stable(regs_out.z);
    endproperty
    a_skip_quiet: assert property (p_skip_quiet)
        else $error("skipped word changed state");
    property p_add;
        live && rom_data_in == OP_ADD_MEM |=>
            regs_out.acc - $past(regs_out.acc) == $past(ram_rdata_in);
    endproperty
    a_add: assert property (p_add)
        else $error("add memory wrong");
    property p_sp_acc;
        live && rom_data_in == OP_STACK_TO_ACC |=>
            regs_out.acc == {1'b0, $past(regs_out.stack_pointer)};
    endproperty
    a_sp_acc: assert property (p_sp_acc)
        else $error("stack pointer transfer wrong");
endmodule // nibble_cpu_exec_properties

bind nibble_cpu_transfer_exec nibble_cpu_exec_properties u_props (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .rom_data_in(rom_data_in), .ram_rdata_in(ram_rdata_in),
    .rom_addr_out(rom_addr_out), .ram_req_out(ram_req_out),
    .regs_out(regs_out), .skip_pending_out(skip_pending_out));

// [dv/nibble_mem_model.sv]
// Partner: program ROM and nibble RAM with same-cycle reads
`timescale 1ns/1ns
module nibble_mem_model
    import nibble_cpu_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic [PC_W-1:0] rom_addr_in,
    input ram_req_type ram_req_in,
    output logic [INSTR_W-1:0] rom_data_out,
    output logic [3:0] ram_rdata_out
);
    logic [INSTR_W-1:0] rom [0:(1<<PC_W)-1];
    logic [3:0] ram [0:(1<<RAM_ADDR_W)-1];
    // Blank words decode as no-ops, so stray fetches stay harmless
    initial begin
        foreach (rom[i]) rom[i] = 10'h000;
        foreach (ram[i]) ram[i] = 4'h0;
    end
    assign rom_data_out = rom[rom_addr_in];
    assign ram_rdata_out = ram[ram_req_in.addr];
    // Write lands on the edge that ends the store cycle
    always @(posedge clk_sys_in) begin
        if (ram_req_in.we) begin
            ram[ram_req_in.addr] <= ram_req_in.wdata;
        end
    end
endmodule // nibble_mem_model

// [dv/tb_top.sv]
// Testbench: program-driven check of the transfer execution core
`timescale 1ns/1ns
module tb_top
    import nibble_cpu_pkg::*;
;
    typedef struct {int cyc; int fld; int adr; logic [12:0] val;} note_type;
    logic clk_sys_in;
    logic rst_b_in = 1'b0;
    logic [INSTR_W-1:0] rom_data;
    logic [3:0] ram_rdata;
    logic [PC_W-1:0] rom_addr;
    ram_req_type ram_req;
    core_regs_type regs;
    logic skip;
    note_type q[$];
    int err_total = 0;
    int compares = 0;
    int ecnt = 0;
    int pcb = 0;
    int cycb = 0;
    logic [3:0] n1, a2;
    logic [3:0] m [1:5];
    logic [5:0] p;
    logic [9:0] tw;
    nibble_cpu_transfer_exec uut (.clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in), .rom_data_in(rom_data), .ram_rdata_in(ram_rdata),
        .rom_addr_out(rom_addr), .ram_req_out(ram_req), .regs_out(regs),
        .skip_pending_out(skip));
    nibble_mem_model mem_i (.clk_sys_in(clk_sys_in), .rom_addr_in(rom_addr),
        .ram_req_in(ram_req), .rom_data_out(rom_data),
        .ram_rdata_out(ram_rdata));
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task automatic report_and_stop();
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Notes of expected values and the watcher
    // ----------------------------------------
    task automatic ex(int f, logic [12:0] v, int a = 0);
        q.push_back('{cycb, f, a, v});
    endtask
    task automatic emit(logic [9:0] w);
        mem_i.rom[pcb] = w;
        pcb++;
        cycb++;
        ex(0, 13'(pcb));
    endtask
    function automatic logic [12:0] getf(int f, int a);
        case (f)
            0: return regs.pc;
            1: return {10'h000, regs.stack_pointer};
            2: return {9'h000, regs.acc};
            3: return {9'h000, regs.b};
            4: return {9'h000, regs.x};
            5: return {9'h000, regs.y};
            6: return {11'h000, regs.z};
            7: return {12'h000, skip};
            default: return {9'h000, mem_i.ram[a]};
        endcase
    endfunction
    always @(posedge clk_sys_in) begin
        if (rst_b_in) ecnt <= ecnt + 1;
    end
    // Compare at the falling edge, once the rising-edge updates settled
    always @(negedge clk_sys_in) begin
        while (q.size() > 0 && q[0].cyc == ecnt) begin
            compares++;
            if (getf(q[0].fld, q[0].adr) !== q[0].val) begin
                err_total++;
                $display("BAD %0t field %0d got %0h exp %0h", $time,
                    q[0].fld, getf(q[0].fld, q[0].adr), q[0].val);
            end
            void'(q.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h7859));
        n1 = 4'($urandom);
        a2 = 4'($urandom);
        foreach (m[i]) m[i] = 4'($urandom);
        p = 6'($urandom % 63 + 1);
        tw = 10'($urandom);
        #1;
        mem_i.ram[10'h21F] = m[1];
        mem_i.ram[10'h22F] = m[2];
        mem_i.ram[10'h27F] = m[3];
        mem_i.ram[10'h270] = m[4];
        mem_i.ram[10'h20F] = m[5];
        mem_i.rom[{p, 7'h07}] = tw;
        emit(OP_PAIR_LOAD | 10'h01F); ex(4, 4'h1); ex(5, 4'hF);
        emit(OP_PAIR_LOAD | 10'h025); ex(4, 4'h1); ex(5, 4'hF);
        emit(OP_Y_INC); ex(5, 4'h0); ex(7, 1'b1);
        emit(OP_ACC_IMM | 10'h00A); ex(2, 4'h0); ex(7, 1'b0);
        emit(OP_ACC_IMM | {6'h00, n1}); ex(2, n1);
        emit(OP_Y_DEC); ex(5, 4'hF); ex(7, 1'b1);
        emit(OP_BANK_LOAD | 10'h001); ex(6, 2'h0);
        emit(OP_BANK_LOAD | 10'h002); ex(6, 2'h2);
        emit(OP_Y_DEC); ex(5, 4'hE); ex(7, 1'b0);
        emit(OP_Y_INC); ex(5, 4'hF); ex(7, 1'b0);
        emit(OP_MEM_TO_ACC | 10'h003); ex(2, m[1]); ex(4, 4'h2);
        emit(OP_ACC_IMM | {6'h00, a2}); ex(2, a2);
        emit(OP_MEM_XCHG | 10'h005); ex(2, m[2]); ex(4, 4'h7);
        ex(8, a2, 'h22F);
        emit(OP_XCHG_INC); ex(2, m[3]); ex(5, 4'h0); ex(7, 1'b1);
        ex(8, m[2], 'h27F);
        emit(OP_ACC_TO_MEM | 10'h00F); ex(4, 4'h7); ex(8, m[4], 'h270);
        emit(OP_XCHG_DEC | 10'h008); ex(2, m[4]); ex(4, 4'hF);
        ex(5, 4'hF); ex(7, 1'b1); ex(8, m[3], 'h270);
        emit(OP_ADD_MEM); ex(2, m[4]);
        emit(OP_ACC_TO_MEM | 10'h00F); ex(4, 4'h0); ex(8, m[4], 'h2FF);
        emit(OP_ADD_MEM); ex(2, (m[4] + m[5]) & 4'hF);
        emit(OP_STACK_TO_ACC); ex(2, 4'h7);
        mem_i.rom[pcb] = OP_TABLE_REF | {4'h0, p};
        cycb++;
        ex(0, {p, 3'h0, 4'h7}); ex(1, 3'h0);
        cycb++;
        ex(3, tw[7:4]); ex(2, tw[3:0]);
        cycb++;
        pcb++;
        ex(0, 13'(pcb)); ex(1, 3'h7);
        emit(OP_PAIR_LOAD | 10'h023); ex(4, 4'h2); ex(5, 4'h3);
        repeat (16) @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        repeat (cycb + 4) @(negedge clk_sys_in);
        if (q.size() != 0) begin
            err_total++;
            $display("BAD %0t %0d notes never checked", $time, q.size());
        end
        report_and_stop();
    end
endmodule // tb_top
